// *** bench/entry_src.sv ***
`timescale 1ns/1ps
module entry_src (
    input  wire logic         pres_i,
    input  wire logic [1:0]   tt_i,
    input  wire logic [2:0]   wenc_i,
    input  wire logic [51:0]  ptr_i,
    input  wire logic [15:0]  dom_i,
    output logic      [127:0] ent_o
);
    // Software side: ignored field is dirtied on purpose to catch misuse
    always_comb begin
        ent_o        = '0;
        ent_o[87:72] = (dom_i == 16'h0000) ? 16'h0001 : dom_i;
        ent_o[70:67] = 4'ha;
        ent_o[66:64] = (tt_i == 2'h2) ? 3'h4 : wenc_i;
        ent_o[63:12] = ptr_i;
        ent_o[3:2]   = tt_i;
        ent_o[0]     = pres_i;
    end
endmodule

// *** bench/tb.sv ***
`timescale 1ns/1ps
module tb;
    logic ref_clk_i = 0, rst_n_i = 0, ps = 0, pe = 0, pw = 0, slv, rdy, irq, rv, flt, pt, pres;
    logic [7:0] pa = 0;
    logic [31:0] pwd = 0, prd, q;
    logic [2:0] lv, wenc;
    logic [63:0] wb;
    logic [15:0] dt, dom;
    logic [1:0] tt;
    logic [51:0] ptr;
    logic [127:0] ent;
    int failures = 0, checks_done = 0, w;
    always #2.5 ref_clk_i = ~ref_clk_i;
    context_entry_decode u_context_entry_decode (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
        .ce_i(1'b1), .psel_i(ps), .penable_i(pe), .pwrite_i(pw), .paddr_i(pa),
        .pwdata_i(pwd), .prdata_o(prd), .pready_o(rdy), .pslverr_o(slv), .irq_o(irq),
        .result_valid_o(rv), .fault_o(flt), .pass_through_o(pt), .walk_levels_o(lv),
        .walk_base_o(wb), .domain_tag_o(dt));
    entry_src u_entry_src (.pres_i(pres), .tt_i(tt), .wenc_i(wenc), .ptr_i(ptr), .dom_i(dom),
        .ent_o(ent));
    ////////////////////////////////////////////////////////////////////////////
    task close_out;
        $display("failures=%0d checks=%0d", failures, checks_done);
        if (failures == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task chk(input string n, input logic [63:0] e, input logic [63:0] g);
        checks_done++;
        if (g !== e) begin
            $display("CHECK FAILED %s exp %h got %h", n, e, g);
            failures++;
        end
    endtask
    // Ready and read data are read at the rising edge, before that edge's updates land
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        ps <= 1; pe <= 0; pw <= wr; pa <= a; pwd <= d;
        @(posedge ref_clk_i);
        pe <= 1;
        n = 0;
        do begin @(posedge ref_clk_i); n++; end while (rdy !== 1'b1 && n < 50);
        if (rdy !== 1'b1) begin failures++; close_out(); end
        q = prd;
        ps <= 0; pe <= 0;
        @(posedge ref_clk_i);
    endtask
    task dec(input logic [1:0] k, input logic f, input logic [2:0] l, input logic [63:0] b,
             input logic [15:0] d, input logic p, input logic [63:0] ad);
        int n;
        @(posedge ref_clk_i);
        for (int i = 0; i < 4; i++) apb(1, 8'(4 * i), ent[32*i+:32]);
        apb(1, context_entry_pkg::OFS_ADDR_LO, ad[31:0]);
        apb(1, context_entry_pkg::OFS_ADDR_HI, ad[63:32]);
        apb(1, context_entry_pkg::OFS_CTRL, {29'h0, k, 1'b1});
        n = 0;
        while (rv !== 1'b1 && n < 20) begin @(negedge ref_clk_i); n++; end
        if (n >= 20) begin failures++; close_out(); end
        chk("fault", f, flt);
        chk("levels", l, lv);
        chk("base", b, wb);
        chk("domain", d, dt);
        chk("pass", p, pt);
        @(negedge ref_clk_i);
        chk("valid_pulse", 0, rv);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        pres = 1; tt = 0; ptr = 52'h12345; dom = 16'h00a0;
        repeat (3) @(posedge ref_clk_i);
        rst_n_i <= 1;
        @(posedge ref_clk_i);
        apb(0, context_entry_pkg::OFS_CAP, 0);
        chk("cap", 32'h0000301f, q);
        apb(0, 8'h40, 0);
        chk("slverr", 1, slv);
        for (int a = 0; a < 8; a++) begin
            wenc = 3'(a);
            w = (a == 4) ? 64 : 30 + 9 * a;
            dec(0, a > 4, (a > 4) ? 3'h0 : 3'(a + 2), (a > 4) ? 64'h0 : {ptr, 12'h000}, dom, 0,
                (a > 4) ? 64'h0 : (64'h1 << w) - 64'h1);
        end
        wenc = 1;
        dec(0, 1, 0, 0, dom, 0, 64'h1 << 39);
        wenc = 2; ptr = 52'h1 << 36;
        dec(0, 1, 0, 0, dom, 0, 64'h0);
        tt = 2;
        dec(0, 0, 0, 0, dom, 1, 64'h1 << 63);
        dec(1, 1, 0, 0, dom, 0, 64'h0);
        tt = 1; ptr = 52'h12345;
        dec(1, 0, 3'h4, {ptr, 12'h000}, dom, 0, 64'h0);
        dec(0, 1, 0, 0, dom, 0, 64'h1 << 48);
        tt = 0;
        dec(2, 1, 0, 0, dom, 0, 64'h0);
        tt = 3;
        dec(0, 1, 0, 0, dom, 0, 64'h0);
        tt = 0;
        apb(1, context_entry_pkg::OFS_CAP, 32'h0000_301b);
        dec(0, 1, 0, 0, dom, 0, 64'h0);
        pres = 0;
        dec(0, 1, 0, 0, 16'h0000, 0, 64'h0);
        chk("irq_masked", 0, irq);
        apb(1, context_entry_pkg::OFS_INT_MASK, 32'h2);
        @(negedge ref_clk_i);
        chk("irq_on", 1, irq);
        apb(1, context_entry_pkg::OFS_INT_STAT, 32'h3);
        @(negedge ref_clk_i);
        chk("irq_clr", 0, irq);
        close_out();
    end
endmodule

// *** hw/context_entry_decode.sv ***
// The APB register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module context_entry_decode (
    input  wire logic        ref_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        ce_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic [31:0]      prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    output logic             irq_o,
    output logic             result_valid_o,
    output logic             fault_o,
    output logic             pass_through_o,
    output logic [2:0]       walk_levels_o,
    output logic [63:0]      walk_base_o,
    output logic [15:0]      domain_tag_o
);

    ////////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        context_entry_pkg::eval_state_e  st;
        logic [127:0]                    entry;
        logic [63:0]                     addr;
        logic [1:0]                      kind;
        logic [4:0]                      wset;
        logic [6:0]                      hostw;
        logic                            cache_mode;
        logic                            valid;
        logic                            done;
        logic                            fault;
        logic                            pass;
        logic                            tag_warn;
        logic [2:0]                      levels;
        logic [6:0]                      width;
        context_entry_pkg::fault_cause_e cause;
        logic [15:0]                     dom;
        logic [63:0]                     base;
        logic [1:0]                      ists;
        logic [1:0]                      imask;
        logic                            rd_ok;
        logic [31:0]                     prdata;
        logic                            pslverr;
    } state_s;

    state_s state_r;
    state_s state_nxt;

    logic        present;
    logic        frdis;
    logic [1:0]  tt;
    logic [2:0]  wfield;
    logic [63:0] ptr;
    logic        wfield_ok;
    logic [6:0]  wf_width;
    logic [2:0]  wf_levels;
    logic        oor;
    logic        ptr_rsvd;
    logic [7:0]  wset_ext;
    logic        access_done;
    logic        wr_en;
    logic [31:0] rdata_c;
    logic        hit_c;
    logic [31:0] result_word;

    localparam int TAG_MSB = context_entry_pkg::TAG_W - 1;

    ////////////////////////////////////////////////////////////////////////////
    // Entry fields

    assign present   = state_r.entry[context_entry_pkg::PRESENT_BIT];
    assign frdis     = state_r.entry[context_entry_pkg::FRDIS_BIT];
    assign tt        = state_r.entry[context_entry_pkg::TT_LSB +: 2];
    assign wfield    = state_r.entry[context_entry_pkg::WF_LSB +: 3];
    // Bits 70:67 are sliced only for the APB read-back, so they cannot reach any decision
    assign ptr       = {state_r.entry[context_entry_pkg::PTR_MSB:
                                      context_entry_pkg::PTR_LSB], 12'h000};
    assign wset_ext  = {3'h0, state_r.wset};

    width_check u_width_check (
        .wfield_i       (wfield),
        .addr_i         (state_r.addr),
        .ptr_i          (ptr),
        .hostw_i        (state_r.hostw),
        .wfield_ok_o    (wfield_ok),
        .width_o        (wf_width),
        .levels_o       (wf_levels),
        .out_of_range_o (oor),
        .ptr_rsvd_o     (ptr_rsvd)
    );

    ////////////////////////////////////////////////////////////////////////////
    // APB read mux

    assign access_done = psel_i & penable_i & pready_o;
    assign wr_en       = access_done & pwrite_i & ~state_r.pslverr;

    always_comb begin
        result_word = 32'h0000_0000;
        result_word[context_entry_pkg::RES_BUSY]     = (state_r.st == context_entry_pkg::ST_EVAL);
        result_word[context_entry_pkg::RES_VALID]    = state_r.valid;
        result_word[context_entry_pkg::RES_FAULT]    = state_r.fault;
        result_word[context_entry_pkg::RES_PASS]     = state_r.pass;
        result_word[context_entry_pkg::RES_TAG_WARN] = state_r.tag_warn;
        result_word[context_entry_pkg::RES_LEVELS +: 3] = state_r.levels;
        result_word[context_entry_pkg::RES_WIDTH +: 7]  = state_r.width;
        result_word[context_entry_pkg::RES_CAUSE +: 4]  = state_r.cause;
    end

    always_comb begin
        rdata_c = 32'h0000_0000;
        hit_c   = 1'b1;
        if (paddr_i == context_entry_pkg::OFS_ENTRY0) begin
            rdata_c = state_r.entry[31:0];
        end else if (paddr_i == context_entry_pkg::OFS_ENTRY1) begin
            rdata_c = state_r.entry[63:32];
        end else if (paddr_i == context_entry_pkg::OFS_ENTRY2) begin
            rdata_c = state_r.entry[95:64];
        end else if (paddr_i == context_entry_pkg::OFS_ENTRY3) begin
            rdata_c = state_r.entry[127:96];
        end else if (paddr_i == context_entry_pkg::OFS_ADDR_LO) begin
            rdata_c = state_r.addr[31:0];
        end else if (paddr_i == context_entry_pkg::OFS_ADDR_HI) begin
            rdata_c = state_r.addr[63:32];
        end else if (paddr_i == context_entry_pkg::OFS_CTRL) begin
            rdata_c[context_entry_pkg::CTRL_KIND_LSB +: 2] = state_r.kind;
        end else if (paddr_i == context_entry_pkg::OFS_CAP) begin
            rdata_c[context_entry_pkg::CAP_WSET_LSB +: 5]  = state_r.wset;
            rdata_c[context_entry_pkg::CAP_HOSTW_LSB +: 7] = state_r.hostw;
            rdata_c[context_entry_pkg::CAP_CACHE_BIT]      = state_r.cache_mode;
        end else if (paddr_i == context_entry_pkg::OFS_RESULT) begin
            rdata_c = result_word;
        end else if (paddr_i == context_entry_pkg::OFS_DOMAIN) begin
            rdata_c[TAG_MSB:0] = state_r.dom;
        end else if (paddr_i == context_entry_pkg::OFS_BASE_LO) begin
            rdata_c = state_r.base[31:0];
        end else if (paddr_i == context_entry_pkg::OFS_BASE_HI) begin
            rdata_c = state_r.base[63:32];
        end else if (paddr_i == context_entry_pkg::OFS_INT_STAT) begin
            rdata_c[1:0] = state_r.ists;
        end else if (paddr_i == context_entry_pkg::OFS_INT_MASK) begin
            rdata_c[1:0] = state_r.imask;
        end else begin
            hit_c = 1'b0;
        end
    end


    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        logic [1:0]                      ev;
        logic [1:0]                      clr;
        context_entry_pkg::fault_cause_e cause;
        ev        = 2'h0;
        clr       = 2'h0;
        cause     = context_entry_pkg::CAUSE_NONE;
        state_nxt = state_r;
        state_nxt.done = 1'b0;

        // Read data is caught one cycle before pready, so prdata is a flop
        if (psel_i && !state_r.rd_ok) begin
            state_nxt.rd_ok   = 1'b1;
            state_nxt.prdata  = rdata_c;
            state_nxt.pslverr = ~hit_c;
        end
        if (access_done) begin
            state_nxt.rd_ok = 1'b0;
        end

        if (wr_en) begin
            if (paddr_i == context_entry_pkg::OFS_ENTRY0) begin
                state_nxt.entry[31:0] = pwdata_i;
            end else if (paddr_i == context_entry_pkg::OFS_ENTRY1) begin
                state_nxt.entry[63:32] = pwdata_i;
            end else if (paddr_i == context_entry_pkg::OFS_ENTRY2) begin
                state_nxt.entry[95:64] = pwdata_i;
            end else if (paddr_i == context_entry_pkg::OFS_ENTRY3) begin
                state_nxt.entry[127:96] = pwdata_i;
            end else if (paddr_i == context_entry_pkg::OFS_ADDR_LO) begin
                state_nxt.addr[31:0] = pwdata_i;
            end else if (paddr_i == context_entry_pkg::OFS_ADDR_HI) begin
                state_nxt.addr[63:32] = pwdata_i;
            end else if (paddr_i == context_entry_pkg::OFS_CTRL) begin
                // A start while busy is dropped; the one in flight finishes
                if (pwdata_i[context_entry_pkg::CTRL_GO_BIT] &&
                    state_r.st == context_entry_pkg::ST_IDLE) begin
                    state_nxt.kind = pwdata_i[context_entry_pkg::CTRL_KIND_LSB +: 2];
                    state_nxt.st   = context_entry_pkg::ST_EVAL;
                end
            end else if (paddr_i == context_entry_pkg::OFS_CAP) begin
                state_nxt.wset       = pwdata_i[context_entry_pkg::CAP_WSET_LSB +: 5];
                state_nxt.hostw      = pwdata_i[context_entry_pkg::CAP_HOSTW_LSB +: 7];
                state_nxt.cache_mode = pwdata_i[context_entry_pkg::CAP_CACHE_BIT];
            end else if (paddr_i == context_entry_pkg::OFS_INT_STAT) begin
                clr = pwdata_i[1:0];
            end else if (paddr_i == context_entry_pkg::OFS_INT_MASK) begin
                state_nxt.imask = pwdata_i[1:0];
            end
        end

        case (state_r.st)
            context_entry_pkg::ST_IDLE: begin
            end
            context_entry_pkg::ST_EVAL: begin
                if (!present) begin
                    cause = context_entry_pkg::CAUSE_ABSENT;
                end else if (tt == context_entry_pkg::TT_RSVD) begin
                    cause = context_entry_pkg::CAUSE_RSVD_TT;
                end else if (tt == context_entry_pkg::TT_PASS) begin
                    if (state_r.kind != context_entry_pkg::KIND_UNTRANS) begin
                        cause = context_entry_pkg::CAUSE_BLOCKED;
                    end
                end else if (tt == context_entry_pkg::TT_WALK &&
                             state_r.kind != context_entry_pkg::KIND_UNTRANS) begin
                    cause = context_entry_pkg::CAUSE_BLOCKED;
                end else if (!wfield_ok) begin
                    cause = context_entry_pkg::CAUSE_RSVD_WF;
                end else if (!wset_ext[wfield]) begin
                    cause = context_entry_pkg::CAUSE_UNSUP_WF;
                end else if (ptr_rsvd) begin
                    cause = context_entry_pkg::CAUSE_PTR_RSVD;
                end else if (state_r.kind == context_entry_pkg::KIND_UNTRANS && oor) begin
                    cause = context_entry_pkg::CAUSE_RANGE;
                end

                state_nxt.cause  = cause;
                state_nxt.fault  = (cause != context_entry_pkg::CAUSE_NONE);
                state_nxt.pass   = 1'b0;
                state_nxt.levels = 3'h0;
                state_nxt.width  = 7'h00;
                state_nxt.base   = 64'h0;
                state_nxt.dom    = 16'h0000;
                state_nxt.tag_warn = 1'b0;
                if (present) begin
                    state_nxt.dom = state_r.entry[context_entry_pkg::TAG_LSB +:
                                                  context_entry_pkg::TAG_W];
                    // Flags a software slip; hardware still decodes the entry
                    state_nxt.tag_warn = state_r.cache_mode && (state_nxt.dom == 16'h0000);
                end
                if (cause == context_entry_pkg::CAUSE_NONE) begin
                    if (tt == context_entry_pkg::TT_PASS) begin
                        state_nxt.pass = 1'b1;
                    end else begin
                        state_nxt.levels = wf_levels;
                        state_nxt.width  = wf_width;
                        state_nxt.base   = ptr;
                    end
                end
                state_nxt.valid = 1'b1;
                state_nxt.done  = 1'b1;
                state_nxt.st    = context_entry_pkg::ST_IDLE;
                ev[context_entry_pkg::INT_DONE] = 1'b1;
                // Report disable only silences the fault event, even when absent
                ev[context_entry_pkg::INT_FAULT] = state_nxt.fault & ~frdis;
            end
            default: begin
                state_nxt.st = context_entry_pkg::ST_IDLE;
            end
        endcase

        // Set wins over a clear in the same cycle
        state_nxt.ists = (state_r.ists & ~clr) | ev;
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_r       <= '0;
            state_r.wset  <= context_entry_pkg::WSET_RST;
            state_r.hostw <= context_entry_pkg::HOSTW_RST;
        end else if (ce_i) begin
            state_r <= state_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign prdata_o       = state_r.prdata;
    assign pslverr_o      = state_r.pslverr;
    assign pready_o       = psel_i & penable_i & state_r.rd_ok & ce_i;
    assign irq_o          = |(state_r.ists & state_r.imask);
    assign result_valid_o = state_r.done;
    assign fault_o        = state_r.fault;
    assign pass_through_o = state_r.pass;
    assign walk_levels_o  = state_r.levels;
    assign walk_base_o    = state_r.base;
    assign domain_tag_o   = state_r.dom;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    logic eval_now;
    assign eval_now = ce_i && state_r.st == context_entry_pkg::ST_EVAL;

    a_range_fault: assert property (eval_now && present
        && (tt == context_entry_pkg::TT_WALK || tt == context_entry_pkg::TT_WALK_DTLB)
        && wfield_ok && wset_ext[wfield] && !ptr_rsvd && oor
        && state_r.kind == context_entry_pkg::KIND_UNTRANS
        |=> fault_o && state_r.cause == context_entry_pkg::CAUSE_RANGE)
        else $error("out of range address not faulted");

    a_pass_no_base: assert property (result_valid_o && pass_through_o
        |-> walk_base_o == 64'h0 && walk_levels_o == 3'h0 && !fault_o)
        else $error("pass-through used the table pointer");

    a_domain_slice: assert property (eval_now && present
        |=> domain_tag_o == $past(state_r.entry[context_entry_pkg::TAG_LSB +:
                                                 context_entry_pkg::TAG_W]))
        else $error("domain tag taken from wrong bits");

    a_width_reserved: assert property (eval_now && present
        && tt != context_entry_pkg::TT_PASS && tt != context_entry_pkg::TT_RSVD && !wfield_ok
        && !(tt == context_entry_pkg::TT_WALK && state_r.kind != context_entry_pkg::KIND_UNTRANS)
        |=> fault_o && state_r.cause == context_entry_pkg::CAUSE_RSVD_WF)
        else $error("reserved width did not fault");

    a_absent_entry: assert property (eval_now && !present
        |=> fault_o && walk_base_o == 64'h0 && domain_tag_o == 16'h0000
            && (state_r.ists[context_entry_pkg::INT_FAULT] == !$past(frdis)
                || $past(state_r.ists[context_entry_pkg::INT_FAULT])))
        else $error("absent entry not handled");

    a_pass_blocks: assert property (eval_now && present && tt == context_entry_pkg::TT_PASS
        |=> fault_o == ($past(state_r.kind) != context_entry_pkg::KIND_UNTRANS))
        else $error("pass-through kind handling wrong");

    a_base_aligned: assert property (result_valid_o && !fault_o && !pass_through_o
        |-> walk_base_o[11:0] == 12'h000 && walk_levels_o >= context_entry_pkg::LEVELS_2)
        else $error("walk base not aligned or depth missing");

    a_ptr_reserved: assert property (eval_now && present && tt == context_entry_pkg::TT_WALK
        && state_r.kind == context_entry_pkg::KIND_UNTRANS && wfield_ok && wset_ext[wfield]
        && ptr_rsvd |=> fault_o && state_r.cause == context_entry_pkg::CAUSE_PTR_RSVD)
        else $error("reserved pointer bits not faulted");

    a_width_depth: assert property (result_valid_o && !fault_o && !pass_through_o
        |-> walk_levels_o == $past(wf_levels) && state_r.width == $past(wf_width))
        else $error("walk depth not from width field");

endmodule

// *** hw/context_entry_pkg.sv ***
package context_entry_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_ENTRY0   = 8'h00;
    localparam logic [7:0] OFS_ENTRY1   = 8'h04;
    localparam logic [7:0] OFS_ENTRY2   = 8'h08;
    localparam logic [7:0] OFS_ENTRY3   = 8'h0c;
    localparam logic [7:0] OFS_ADDR_LO  = 8'h10;
    localparam logic [7:0] OFS_ADDR_HI  = 8'h14;
    localparam logic [7:0] OFS_CTRL     = 8'h18;
    localparam logic [7:0] OFS_CAP      = 8'h1c;
    localparam logic [7:0] OFS_RESULT   = 8'h20;
    localparam logic [7:0] OFS_DOMAIN   = 8'h24;
    localparam logic [7:0] OFS_BASE_LO  = 8'h28;
    localparam logic [7:0] OFS_BASE_HI  = 8'h2c;
    localparam logic [7:0] OFS_INT_STAT = 8'h30;
    localparam logic [7:0] OFS_INT_MASK = 8'h34;

    // Entry field positions
    localparam int PRESENT_BIT = 0;
    localparam int FRDIS_BIT   = 1;
    localparam int TT_LSB      = 2;
    localparam int PTR_LSB     = 12;
    localparam int PTR_MSB     = 63;
    localparam int WF_LSB      = 64;
    localparam int TAG_LSB     = 72;
    localparam int TAG_W       = 16;

    // Translation types and request kinds
    localparam logic [1:0] TT_WALK      = 2'h0;
    localparam logic [1:0] TT_WALK_DTLB = 2'h1;
    localparam logic [1:0] TT_PASS      = 2'h2;
    localparam logic [1:0] TT_RSVD      = 2'h3;
    localparam logic [1:0] KIND_UNTRANS = 2'h0;

    // Address width encodings and their meaning
    localparam logic [2:0] WENC_30 = 3'h0;
    localparam logic [2:0] WENC_39 = 3'h1;
    localparam logic [2:0] WENC_48 = 3'h2;
    localparam logic [2:0] WENC_57 = 3'h3;
    localparam logic [2:0] WENC_64 = 3'h4;
    localparam logic [6:0] WIDTH_30 = 7'h1e;
    localparam logic [6:0] WIDTH_39 = 7'h27;
    localparam logic [6:0] WIDTH_48 = 7'h30;
    localparam logic [6:0] WIDTH_57 = 7'h39;
    localparam logic [6:0] WIDTH_64 = 7'h40;
    localparam logic [2:0] LEVELS_2 = 3'h2;
    localparam logic [2:0] LEVELS_3 = 3'h3;
    localparam logic [2:0] LEVELS_4 = 3'h4;
    localparam logic [2:0] LEVELS_5 = 3'h5;
    localparam logic [2:0] LEVELS_6 = 3'h6;

    // Control, capability, result and interrupt fields
    localparam int CTRL_GO_BIT   = 0;
    localparam int CTRL_KIND_LSB = 1;
    localparam int CAP_WSET_LSB  = 0;
    localparam int CAP_HOSTW_LSB = 8;
    localparam int CAP_CACHE_BIT = 16;
    localparam int RES_BUSY      = 0;
    localparam int RES_VALID     = 1;
    localparam int RES_FAULT     = 2;
    localparam int RES_PASS      = 3;
    localparam int RES_TAG_WARN  = 4;
    localparam int RES_LEVELS    = 8;
    localparam int RES_WIDTH     = 12;
    localparam int RES_CAUSE     = 20;
    localparam int INT_DONE      = 0;
    localparam int INT_FAULT     = 1;

    // Reset values
    localparam logic [4:0] WSET_RST  = 5'h1f;
    localparam logic [6:0] HOSTW_RST = 7'h30;

    typedef enum logic [3:0] {
        CAUSE_NONE     = 4'h0,
        CAUSE_ABSENT   = 4'h1,
        CAUSE_RSVD_TT  = 4'h2,
        CAUSE_BLOCKED  = 4'h3,
        CAUSE_RSVD_WF  = 4'h4,
        CAUSE_UNSUP_WF = 4'h5,
        CAUSE_PTR_RSVD = 4'h6,
        CAUSE_RANGE    = 4'h7
    } fault_cause_e;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_EVAL = 1'b1
    } eval_state_e;

endpackage

// *** hw/width_check.sv ***
`timescale 1ns/1ps
module width_check (
    input  wire logic [2:0]  wfield_i,
    input  wire logic [63:0] addr_i,
    input  wire logic [63:0] ptr_i,
    input  wire logic [6:0]  hostw_i,
    output logic             wfield_ok_o,
    output logic [6:0]       width_o,
    output logic [2:0]       levels_o,
    output logic             out_of_range_o,
    output logic             ptr_rsvd_o
);
    logic [63:0] oor_bits;
    logic [63:0] ptr_bits;

    always_comb begin
        wfield_ok_o = 1'b1;
        width_o     = context_entry_pkg::WIDTH_30;
        levels_o    = context_entry_pkg::LEVELS_2;
        case (wfield_i)
            context_entry_pkg::WENC_30: begin
                width_o  = context_entry_pkg::WIDTH_30;
                levels_o = context_entry_pkg::LEVELS_2;
            end
            context_entry_pkg::WENC_39: begin
                width_o  = context_entry_pkg::WIDTH_39;
                levels_o = context_entry_pkg::LEVELS_3;
            end
            context_entry_pkg::WENC_48: begin
                width_o  = context_entry_pkg::WIDTH_48;
                levels_o = context_entry_pkg::LEVELS_4;
            end
            context_entry_pkg::WENC_57: begin
                width_o  = context_entry_pkg::WIDTH_57;
                levels_o = context_entry_pkg::LEVELS_5;
            end
            context_entry_pkg::WENC_64: begin
                width_o  = context_entry_pkg::WIDTH_64;
                levels_o = context_entry_pkg::LEVELS_6;
            end
            default: begin
                wfield_ok_o = 1'b0;
            end
        endcase
    end

    // Any set bit at or above the limit flags the whole word
    for (genvar i = 0; i < 64; i++) begin : g_bit
        assign oor_bits[i] = addr_i[i] & (7'(i) >= width_o);
        assign ptr_bits[i] = ptr_i[i] & (7'(i) >= hostw_i);
    end

    assign out_of_range_o = |oor_bits;
    assign ptr_rsvd_o     = |ptr_bits;
endmodule
